/* File: tb/tb.sv */
// Self-checking bench for the eight-channel time-slot aware DMA controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                          mclk_in = 1'b0;
    logic                          reset_in = 1'b1;
    tdmdma_pkg::tdmdma_cfg_t [7:0] cfg = '0;
    logic [7:0]                    start = 8'h00;
    logic [7:0]                    clr = 8'h00;
    logic [3:0]                    req = 4'h0;
    logic [3:0][15:0]              pdata = '0;
    logic                          stall = 1'b0;
    logic                          m_rdy, m_rv, m_v, m_w, m_s, tx_v, irq;
    logic [15:0]                   m_rd, m_a, m_wd, tx_d;
    logic [1:0]                    tx_p;
    logic [7:0]                    busy, done;
    logic [17:0]                   tx_q[$];
    int                            num_errors = 0;
    int                            cmp_count = 0;
    int                            irq_n = 0;
    logic [15:0]                   j;
    logic [15:0]                   slot_addr;

    tdmdma_ctrl i_dut (.mclk_in(mclk_in), .reset_in(reset_in), .cfg_in(cfg),
        .start_in(start), .status_clear_in(clr), .periph_req_in(req),
        .periph_rdata_in(pdata), .mem_ready_in(m_rdy), .mem_rvalid_in(m_rv),
        .mem_rdata_in(m_rd), .mem_valid_out(m_v), .mem_write_out(m_w),
        .mem_space_out(m_s), .mem_addr_out(m_a), .mem_wdata_out(m_wd),
        .tx_valid_out(tx_v), .tx_periph_out(tx_p), .tx_data_out(tx_d),
        .busy_out(busy), .done_status_out(done), .irq_out(irq));
    tdmdma_mem_model i_mem (.mclk_in(mclk_in), .reset_in(reset_in), .stall_in(stall),
        .valid_in(m_v), .write_in(m_w), .space_in(m_s), .addr_in(m_a),
        .wdata_in(m_wd), .ready_out(m_rdy), .rvalid_out(m_rv), .rdata_out(m_rd));

    // The clock toggles every half period of 2.5 ns.
    always #2.5 mclk_in = ~mclk_in;

    // One-cycle outputs are counted at the falling edge, where they are settled.
    always @(negedge mclk_in) begin
        if (irq === 1'b1) irq_n++;
        if (tx_v === 1'b1) tx_q.push_back({tx_p, tx_d});
    end

    task automatic check(input string name, input logic [32:0] exp, input logic [32:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic pulse_start(input int ch, input tdmdma_pkg::tdmdma_cfg_t c);
        @(negedge mclk_in);
        cfg[ch] = c;
        start[ch] = 1'b1;
        @(negedge mclk_in);
        start = 8'h00;
    endtask
    task automatic request(input int p, input logic [15:0] w, input int gap);
        req[p] = 1'b1;
        pdata[p] = w;
        @(negedge mclk_in);
        req = 4'h0;
        repeat (gap) @(negedge mclk_in);
    endtask
    task automatic wait_writes(input int n);
        for (int i = 0; i < 200 && i_mem.wr_q.size() < n; i++) @(negedge mclk_in);
        repeat (4) @(negedge mclk_in);
        check("writes", n, i_mem.wr_q.size());
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #20000;
        num_errors++;
        results();
    end

    // Main sequence: sequential, indexed and read channels in turn.
    initial begin
        repeat (5) @(negedge mclk_in);
        reset_in = 1'b0;
        @(negedge mclk_in);
        check("busy", 8'h00, busy);
        check("status", 8'h00, done);
        pulse_start(0, '{2'h1, 1'b1, 1'b1, 1'b1, 16'h0010, 16'h0003, 8'h02});
        stall = 1'b1;
        for (j = 16'h0000; j < 16'h0003; j++) begin
            request(1, 16'h1000 + j, 1);
        end
        stall = 1'b0;
        wait_writes(3);
        for (j = 16'h0000; j < 16'h0003; j++) begin
            check("seq", {1'b1, 16'h0010 + j, 16'h1000 + j}, i_mem.wr_q[j]);
        end
        check("irq", 1, irq_n);
        check("status", 8'h01, done);
        request(1, 16'hdead, 6);
        check("ignored", 3, i_mem.wr_q.size());
        check("sticky", 8'h01, done);
        clr = 8'h01;
        @(negedge mclk_in);
        clr = 8'h00;
        @(negedge mclk_in);
        check("cleared", 8'h00, done);
        pulse_start(6, '{2'h2, 1'b1, 1'b0, 1'b1, 16'h0100, 16'h0002, 8'h03});
        for (j = 16'h0000; j < 16'h0006; j++) begin
            request(2, 16'h2000 + j, 1);
        end
        wait_writes(9);
        for (j = 16'h0000; j < 16'h0006; j++) begin
            slot_addr = 16'h0100 + (j % 16'h0003) * 16'h0002 + j / 16'h0003;
            check("slot", {1'b0, slot_addr, 16'h2000 + j}, i_mem.wr_q[j + 3]);
        end
        check("irq", 2, irq_n);
        check("status", 8'h40, done);
        pulse_start(5, '{2'h3, 1'b0, 1'b1, 1'b1, 16'h0200, 16'h0002, 8'h04});
        for (j = 16'h0000; j < 16'h0002; j++) begin
            request(3, 16'h0000, 12);
        end
        check("tx count", 2, tx_q.size());
        for (j = 16'h0000; j < 16'h0002; j++) begin
            check("tx", {2'h3, (16'h0200 + j) ^ 16'ha5a5}, tx_q[j]);
        end
        check("status", 8'h60, done);
        check("busy", 8'h00, busy);
        results();
    end
endmodule
`default_nettype wire

/* File: tb/tdmdma_mem_model.sv */
// Internal RAM model that answers the controller's memory port.
`timescale 1ns/100ps
`default_nettype none
module tdmdma_mem_model (
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic        stall_in,
    input  wire logic        valid_in,
    input  wire logic        write_in,
    input  wire logic        space_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] wdata_in,
    output logic             ready_out,
    output logic             rvalid_out = 1'b0,
    output logic [15:0]      rdata_out = 16'h0000
);
    tdmdma_pkg::tdmdma_wr_t wr_q[$];
    logic [1:0]             wait_cnt;
    logic                   rd_pend;
    logic [15:0]            rd_addr;

    // Ready is high whenever the bench does not stall the port; a beat that comes while a read is pending is dropped.
    assign ready_out = !stall_in;

    // Writes are logged; a read answers later, and idle data keeps toggling.
    always @(posedge mclk_in) begin
        rvalid_out <= 1'b0;
        rdata_out  <= ~rdata_out;
        if (reset_in) begin
            rd_pend <= 1'b0;
        end else if (rd_pend) begin
            wait_cnt <= wait_cnt - 2'h1;
            if (wait_cnt == 2'h0) begin
                rd_pend    <= 1'b0;
                rvalid_out <= 1'b1;
                rdata_out  <= rd_addr ^ 16'ha5a5;
            end
        end else if (valid_in && ready_out) begin
            if (write_in) begin
                wr_q.push_back({space_in, addr_in, wdata_in});
            end else begin
                rd_pend  <= 1'b1;
                wait_cnt <= 2'h2;
                rd_addr  <= addr_in;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/tdmdma_ctrl.sv */
// Eight-channel DMA controller with sequential and time-slot indexed channels.
//
// Operation
// - Eight channels: four sequential, four indexed-capable.
// - Move words between internal RAM and peripherals.
// - Sequential channels step consecutively, never indexed.
// - One word transfer per peripheral request.
// - Pointer advances after each serviced request.
// - Sequential length reached: interrupt, end channel.
// - Indexed channels offer sequential and indexed modes.
// - Indexed mode for serial ports; others sequential.
// - Each buffer holds one time slot.
// - Length and buffer count drive automatic pointer updates.
// - Frame end moves pointer to next frame.
// - Last location of last buffer: interrupt, status, end.
`timescale 1ns/100ps
`default_nettype none
module tdmdma_ctrl (
    input  wire logic                                      mclk_in,
    input  wire logic                                      reset_in,
    input  wire tdmdma_pkg::tdmdma_cfg_t [tdmdma_pkg::CHANNELS-1:0] cfg_in,
    input  wire logic [tdmdma_pkg::CHANNELS-1:0]           start_in,
    input  wire logic [tdmdma_pkg::CHANNELS-1:0]           status_clear_in,
    input  wire logic [tdmdma_pkg::PERIPHS-1:0]            periph_req_in,
    input  wire logic [tdmdma_pkg::PERIPHS-1:0][tdmdma_pkg::WORD_W-1:0] periph_rdata_in,
    input  wire logic                                      mem_ready_in,
    input  wire logic                                      mem_rvalid_in,
    input  wire logic [tdmdma_pkg::WORD_W-1:0]             mem_rdata_in,
    output logic                                           mem_valid_out,
    output logic                                           mem_write_out,
    output logic                                           mem_space_out,
    output logic [tdmdma_pkg::ADDR_W-1:0]                  mem_addr_out,
    output logic [tdmdma_pkg::WORD_W-1:0]                  mem_wdata_out,
    output logic                                           tx_valid_out,
    output logic [1:0]                                     tx_periph_out,
    output logic [tdmdma_pkg::WORD_W-1:0]                  tx_data_out,
    output logic [tdmdma_pkg::CHANNELS-1:0]                busy_out,
    output logic [tdmdma_pkg::CHANNELS-1:0]                done_status_out,
    output logic                                           irq_out
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        tdmdma_pkg::tdmdma_state_t                             state;
        tdmdma_pkg::tdmdma_chan_t [tdmdma_pkg::CHANNELS-1:0]   chan;
        logic [tdmdma_pkg::CHANNELS-1:0]                       status;
        logic                                                  irq;
        logic                                                  mem_valid;
        logic                                                  mem_write;
        logic                                                  mem_space;
        logic [tdmdma_pkg::ADDR_W-1:0]                         mem_addr;
        logic [tdmdma_pkg::WORD_W-1:0]                         mem_wdata;
        logic                                                  tx_valid;
        logic [1:0]                                            tx_periph;
        logic [tdmdma_pkg::WORD_W-1:0]                         tx_data;
    } tdmdma_ctrl_state_t;

    tdmdma_ctrl_state_t               s;
    tdmdma_ctrl_state_t               next_s;
    logic [tdmdma_pkg::CHANNELS-1:0]  pend_vec;
    logic [tdmdma_pkg::CHANNELS-1:0]  status_set;
    logic [tdmdma_pkg::CHANNELS-1:0]  idx_vec;
    logic [tdmdma_pkg::CH_W-1:0]      pick;
    tdmdma_pkg::tdmdma_chan_t         cur;
    logic                             serve;
    logic                             last;
    logic                             port_free;
    logic                             fifo_in_valid;
    logic                             fifo_in_ready;
    logic                             fifo_out_valid;
    logic                             fifo_out_ready;
    tdmdma_pkg::tdmdma_wr_t           fifo_in_data;
    tdmdma_pkg::tdmdma_wr_t           fifo_out_data;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Lowest-numbered pending channel wins the engine.
    function automatic logic [tdmdma_pkg::CH_W-1:0] first_pending(
        input logic [tdmdma_pkg::CHANNELS-1:0] v);
        logic [tdmdma_pkg::CH_W-1:0] r;
        r = '0;
        for (int i = tdmdma_pkg::CHANNELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = tdmdma_pkg::CH_W'(i);
            end
        end
        return r;
    endfunction

    // Loads a channel from its configuration and arms it.
    function automatic tdmdma_pkg::tdmdma_chan_t chan_load(
        input tdmdma_pkg::tdmdma_cfg_t c, input logic seq_only);
        tdmdma_pkg::tdmdma_chan_t r;
        r = '0;
        r.cfg = c;
        r.cfg.indexed = c.indexed && !seq_only &&
                        (c.periph == tdmdma_pkg::PERIPH_SERIAL0 ||
                         c.periph == tdmdma_pkg::PERIPH_SERIAL1);
        r.active = 1'b1;
        r.ptr = c.base;
        r.count = tdmdma_pkg::COUNT_ZERO;
        r.slot = tdmdma_pkg::SLOT_ZERO;
        return r;
    endfunction

    // True when the current transfer is the final one of the channel.
    function automatic logic is_last(input tdmdma_pkg::tdmdma_chan_t c);
        logic frame_end;
        frame_end = (c.slot + tdmdma_pkg::SLOT_STEP) == c.cfg.buf_count;
        if (c.cfg.indexed) begin
            return frame_end &&
                   ((c.count + tdmdma_pkg::ADDR_STEP) == c.cfg.buf_len);
        end
        return (c.count + tdmdma_pkg::ADDR_STEP) == c.cfg.buf_len;
    endfunction

    // Pointer step after one transfer.
    function automatic tdmdma_pkg::tdmdma_chan_t advance(
        input tdmdma_pkg::tdmdma_chan_t c);
        tdmdma_pkg::tdmdma_chan_t r;
        r = c;
        r.pend = 1'b0;
        if (!c.cfg.indexed) begin
            r.ptr = c.ptr + tdmdma_pkg::ADDR_STEP;
            r.count = c.count + tdmdma_pkg::ADDR_STEP;
        end else if ((c.slot + tdmdma_pkg::SLOT_STEP) == c.cfg.buf_count) begin
            r.count = c.count + tdmdma_pkg::ADDR_STEP;
            r.ptr = c.cfg.base + r.count;
            r.slot = tdmdma_pkg::SLOT_ZERO;
        end else begin
            r.ptr = c.ptr + c.cfg.buf_len;
            r.slot = c.slot + tdmdma_pkg::SLOT_STEP;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Write buffer towards internal memory
    // ------------------------------------------------------------------
    tdmdma_fifo #(
        .WIDTH ($bits(tdmdma_pkg::tdmdma_wr_t)),
        .DEPTH (tdmdma_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .mclk_in       (mclk_in),
        .reset_in      (reset_in),
        .in_valid_in   (fifo_in_valid),
        .in_data_in    (fifo_in_data),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (fifo_out_valid),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (fifo_out_ready)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Arbitration, transfer engine, memory port, requests, status, starts.
    always_comb begin
        next_s = s;
        next_s.irq = 1'b0;
        next_s.tx_valid = 1'b0;
        status_set = '0;
        serve = 1'b0;
        fifo_in_valid = 1'b0;
        fifo_out_ready = 1'b0;
        for (int i = 0; i < tdmdma_pkg::CHANNELS; i++) begin
            pend_vec[i] = s.chan[i].pend && s.chan[i].active;
        end
        pick = first_pending(pend_vec);
        cur = s.chan[pick];
        last = is_last(cur);
        fifo_in_data.space = cur.cfg.space;
        fifo_in_data.addr = cur.ptr;
        fifo_in_data.data = cur.rxw;
        if (s.mem_valid && mem_ready_in) begin
            next_s.mem_valid = 1'b0;
        end
        port_free = !s.mem_valid || mem_ready_in;
        case (s.state)
            tdmdma_pkg::ST_IDLE: begin
                if (pend_vec != '0) begin
                    if (cur.cfg.to_mem) begin
                        fifo_in_valid = 1'b1;
                        serve = fifo_in_ready;
                    end else if (!fifo_out_valid && port_free) begin
                        // Reads wait for queued writes so data order holds.
                        serve = 1'b1;
                        next_s.mem_valid = 1'b1;
                        next_s.mem_write = 1'b0;
                        next_s.mem_space = cur.cfg.space;
                        next_s.mem_addr = cur.ptr;
                        next_s.tx_periph = cur.cfg.periph;
                        next_s.state = tdmdma_pkg::ST_READ;
                    end
                end
            end
            tdmdma_pkg::ST_READ: begin
                if (mem_rvalid_in) begin
                    next_s.tx_valid = 1'b1;
                    next_s.tx_data = mem_rdata_in;
                    next_s.state = tdmdma_pkg::ST_IDLE;
                end
            end
            default: begin
                next_s.state = tdmdma_pkg::ST_IDLE;
            end
        endcase
        if (serve) begin
            next_s.chan[pick] = advance(cur);
            if (last) begin
                next_s.chan[pick].active = 1'b0;
                status_set[pick] = 1'b1;
                next_s.irq = 1'b1;
            end
        end
        // Queued writes drain whenever the port is free.
        if (port_free && fifo_out_valid) begin
            fifo_out_ready = 1'b1;
            next_s.mem_valid = 1'b1;
            next_s.mem_write = 1'b1;
            next_s.mem_space = fifo_out_data.space;
            next_s.mem_addr = fifo_out_data.addr;
            next_s.mem_wdata = fifo_out_data.data;
        end
        // A request is latched with its word; an ended channel drops it.
        for (int i = 0; i < tdmdma_pkg::CHANNELS; i++) begin
            if (next_s.chan[i].active && periph_req_in[s.chan[i].cfg.periph]) begin
                next_s.chan[i].pend = 1'b1;
                next_s.chan[i].rxw = periph_rdata_in[s.chan[i].cfg.periph];
            end
        end
        next_s.status = (s.status & ~status_clear_in) | status_set;
        // A start reloads the channel, overriding the channel updates above; status and interrupt stay.
        for (int i = 0; i < tdmdma_pkg::CHANNELS; i++) begin
            if (start_in[i]) begin
                next_s.chan[i] = chan_load(cfg_in[i], i < tdmdma_pkg::SEQ_CHANNELS);
            end
        end
    end
    // State register.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // All outputs are fields of the state register.
    always_comb begin
        for (int i = 0; i < tdmdma_pkg::CHANNELS; i++) begin
            busy_out[i] = s.chan[i].active;
            idx_vec[i] = s.chan[i].cfg.indexed;
        end
    end
    assign mem_valid_out   = s.mem_valid;
    assign mem_write_out   = s.mem_write;
    assign mem_space_out   = s.mem_space;
    assign mem_addr_out    = s.mem_addr;
    assign mem_wdata_out   = s.mem_wdata;
    assign tx_valid_out    = s.tx_valid;
    assign tx_periph_out   = s.tx_periph;
    assign tx_data_out     = s.tx_data;
    assign done_status_out = s.status;
    assign irq_out         = s.irq;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking chk_cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);
    logic                             h_serve;
    logic                             h_last;
    logic                             h_seq;
    logic                             h_frame_end;
    logic                             h_start;
    logic [tdmdma_pkg::CH_W-1:0]      h_ch;
    logic [tdmdma_pkg::ADDR_W-1:0]    h_ptr;
    // Registers the previous cycle's picked channel and whether it was served, for the checks below.
    always_ff @(posedge mclk_in) begin
        h_serve <= serve && !reset_in;
        h_last <= last;
        h_seq <= !cur.cfg.indexed;
        h_frame_end <= (cur.slot + tdmdma_pkg::SLOT_STEP) == cur.cfg.buf_count;
        h_start <= start_in[pick];
        h_ch <= pick;
        h_ptr <= cur.ptr;
    end
    seq_no_index_a: assert property (idx_vec[tdmdma_pkg::SEQ_CHANNELS-1:0] == '0)
        else $error("Sequential channel holds indexed mode.");
    serve_needs_req_a: assert property (serve |-> cur.pend && cur.active)
        else $error("Transfer without a pending request.");
    seq_step_a: assert property (
        h_serve && h_seq && !h_last && !h_start
        |-> s.chan[h_ch].ptr == h_ptr + tdmdma_pkg::ADDR_STEP)
        else $error("Sequential pointer did not step by one.");
    slot_step_a: assert property (
        h_serve && !h_seq && !h_frame_end && !h_start
        |-> s.chan[h_ch].ptr == h_ptr + s.chan[h_ch].cfg.buf_len)
        else $error("Indexed pointer did not step one buffer.");
    frame_wrap_a: assert property (
        h_serve && !h_seq && h_frame_end && !h_last && !h_start
        |-> s.chan[h_ch].ptr == s.chan[h_ch].cfg.base + s.chan[h_ch].count
            && s.chan[h_ch].slot == '0)
        else $error("Pointer did not move to the next frame.");
    done_ends_a: assert property (
        h_serve && h_last && !h_start |-> irq_out && done_status_out[h_ch] && !busy_out[h_ch])
        else $error("Completion did not end the channel.");
    status_sticky_a: assert property (
        ((done_status_out & ~status_clear_in) != '0)
        |=> ((done_status_out & $past(done_status_out) & ~$past(status_clear_in))
             == ($past(done_status_out) & ~$past(status_clear_in))))
        else $error("Status bit dropped without a clear.");
    irq_cause_a: assert property (irq_out |-> $past(serve) && $past(last))
        else $error("Interrupt without a final transfer.");
    read_order_a: assert property (
        s.state == tdmdma_pkg::ST_IDLE ##1 s.state == tdmdma_pkg::ST_READ
        |-> $past(!fifo_out_valid) && !mem_write_out)
        else $error("Read issued with writes still queued.");
    tx_return_a: assert property (
        s.state == tdmdma_pkg::ST_READ && mem_rvalid_in
        |=> tx_valid_out && tx_data_out == $past(mem_rdata_in))
        else $error("Read word not passed to the peripheral.");
endmodule
`default_nettype wire

/* File: verilog/tdmdma_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module tdmdma_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk_in,
    input  wire logic             reset_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0]   count;
    } tdmdma_fifo_state_t;

    tdmdma_fifo_state_t s;
    tdmdma_fifo_state_t next_s;
    logic [WIDTH-1:0]   mem [DEPTH];
    logic               push;
    logic               pop;

    // Pointer step that wraps at any depth, not only powers of two.
    function automatic logic [PTR_W-1:0] wrap_inc(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction

    // Full and empty come from the word count.
    assign in_ready_out  = (s.count != (PTR_W+1)'(DEPTH));
    assign out_valid_out = (s.count != '0);
    assign out_data_out  = mem[s.rd_ptr];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // Next pointer and count values.
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wr_ptr = wrap_inc(s.wr_ptr);
        end
        if (pop) begin
            next_s.rd_ptr = wrap_inc(s.rd_ptr);
        end
        if (push && !pop) begin
            next_s.count = s.count + (PTR_W+1)'(1);
        end else if (pop && !push) begin
            next_s.count = s.count - (PTR_W+1)'(1);
        end
    end

    // State register.
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Storage array, written on every accepted word.
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem[s.wr_ptr] <= in_data_in;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/tdmdma_pkg.sv */
// Shared constants and types of the time-slot aware DMA controller.
package tdmdma_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int CHANNELS     = 8;
    localparam int SEQ_CHANNELS = 4;
    localparam int CH_W         = 3;
    localparam int PERIPHS      = 4;
    localparam int WORD_W       = 16;
    localparam int ADDR_W       = 16;
    localparam int NBUF_W       = 8;
    localparam int FIFO_DEPTH   = 16;

    // ------------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]        PERIPH_EXT_MEM            = 2'h0;
    localparam logic [1:0]        PERIPH_SERIAL0            = 2'h1;
    localparam logic [1:0]        PERIPH_SERIAL1            = 2'h2;
    localparam logic [1:0]        PERIPH_HOST_PARALLEL_PORT = 2'h3;
    localparam logic              SPACE_INSTR               = 1'b0;
    localparam logic              SPACE_DATA                = 1'b1;
    localparam logic [ADDR_W-1:0] ADDR_STEP                 = 16'h0001;
    localparam logic [ADDR_W-1:0] COUNT_ZERO                = 16'h0000;
    localparam logic [NBUF_W-1:0] SLOT_STEP                 = 8'h01;
    localparam logic [NBUF_W-1:0] SLOT_ZERO                 = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_READ = 1'b1
    } tdmdma_state_t;

    typedef struct packed {
        logic [1:0]        periph;
        logic              to_mem;
        logic              space;
        logic              indexed;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] buf_len;
        logic [NBUF_W-1:0] buf_count;
    } tdmdma_cfg_t;

    typedef struct packed {
        tdmdma_cfg_t       cfg;
        logic              active;
        logic              pend;
        logic [ADDR_W-1:0] ptr;
        logic [ADDR_W-1:0] count;
        logic [NBUF_W-1:0] slot;
        logic [WORD_W-1:0] rxw;
    } tdmdma_chan_t;

    typedef struct packed {
        logic              space;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } tdmdma_wr_t;

endpackage
